// ### bench/dual_gpio_port_ext_mem_override_test.sv
// self-checking bench for the dual gpio port block
`timescale 1ns/1ps
module dual_gpio_port_ext_mem_override_test;
  import gpio_port_pkg::*;
  logic mclk = 0, rstn = 0, io_we = 0, io_re = 0, io_bit_set = 0;
  logic io_bit_clr = 0, xmem_req = 0, xmem_we = 0, xmem_ack, ale, rd_n;
  logic wr_n, ext_mem_enable, ale_q;
  logic [5:0] io_addr = 0;
  logic [2:0] io_bit_sel = 0;
  logic [7:0] io_wdata = 0, io_rdata, xmem_wdata = 0, xmem_rdata, d;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pullup, pb_in, pb_out, pb_oe;
  logic [7:0] pb_pullup, addr_high_out;
  logic [15:0] xmem_addr = 0, ext_val = 0, ext_en = 0;
  logic [11:0] alt = 0;
  logic [27:0] rows [8];
  wire  [6:0]  cin;
  int n_fail = 0, num_checks = 0, nrd, nwr, nale;
  initial forever #2 mclk = ~mclk;
  dual_gpio_port uut (.mclk, .rstn, .io_addr, .io_wdata, .io_we, .io_re,
    .io_bit_set, .io_bit_clr, .io_bit_sel, .io_rdata, .xmem_req, .xmem_we,
    .xmem_addr, .xmem_wdata, .xmem_ack, .xmem_rdata, .pa_in, .pa_out,
    .pa_oe, .pa_pullup, .pb_in, .pb_out, .pb_oe, .pb_pullup,
    .ext_mem_enable, .addr_high_out, .ale, .rd_n, .wr_n,
    .timer0_compare_en(alt[0]), .timer0_compare_out(alt[1]),
    .timer2_compare_en(alt[2]), .timer2_compare_out(alt[3]),
    .serial2_rx_en(alt[4]), .serial2_tx_en(alt[5]),
    .serial2_transmit(alt[6]), .spi_enable(alt[7]), .spi_master(alt[8]),
    .spi_mosi_out(alt[9]), .spi_miso_out(alt[10]), .spi_sck_out(alt[11]),
    .timer0_count_in(cin[0]), .timer1_count_in(cin[1]),
    .serial2_receive(cin[2]), .spi_ss_in(cin[3]), .spi_mosi_in(cin[4]),
    .spi_miso_in(cin[5]), .spi_sck_in(cin[6]));
  pin_sram_model far (.mclk, .pa_out, .pa_oe, .pa_pullup, .pb_out, .pb_oe,
    .pb_pullup, .addr_high_out, .ale, .rd_n, .wr_n, .ext_val, .ext_en,
    .pa_in, .pb_in);
  // strobe activity counters, cleared before each external access
  always @(posedge mclk) begin
    if (!rd_n) nrd++;
    if (!wr_n) nwr++;
    if (ale && !ale_q) nale++;
    ale_q = ale;
  end
  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    io_addr <= a; io_wdata <= v; io_we <= 1;
    @(posedge mclk);
    io_we <= 0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge mclk);
    io_addr <= a; io_re <= 1;
    @(posedge mclk);
    io_re <= 0;
    #1 v = io_rdata;
  endtask
  task automatic bitop(input logic [5:0] a, input logic [2:0] b, input s);
    @(posedge mclk);
    io_addr <= a; io_bit_sel <= b; io_bit_set <= s; io_bit_clr <= !s;
    @(posedge mclk);
    io_bit_set <= 0; io_bit_clr <= 0;
  endtask
  task automatic xm(input w, input logic [15:0] a, input logic [7:0] v);
    int i;
    nrd = 0; nwr = 0; nale = 0;
    @(posedge mclk);
    xmem_req <= 1; xmem_we <= w; xmem_addr <= a; xmem_wdata <= v;
    @(posedge mclk);
    xmem_req <= 0;
    // a refused access acks at once and for one cycle only
    #1;
    for (i = 0; i < 40 && xmem_ack !== 1'b1; i++) @(posedge mclk) #1;
    if (i == 40) begin
      n_fail++;
      conclude();
    end
  endtask
  // ==========================================================================
  // sequence
  initial begin
    // write addr, data, read addr, expected
    rows = '{{6'h1b, 8'ha5, 6'h1b, 8'ha5}, {6'h1a, 8'h3c, 6'h1a, 8'h3c},
      {6'h18, 8'h5a, 6'h18, 8'h5a}, {6'h17, 8'hc3, 6'h17, 8'hc3},
      {6'h19, 8'hff, 6'h1a, 8'h3c}, {6'h16, 8'hff, 6'h17, 8'hc3},
      {6'h3f, 8'h11, 6'h3f, 8'h00}, {6'h35, 8'h00, 6'h35, 8'h00}};
    repeat (16) @(posedge mclk);
    chk("pa_oe in reset", pa_oe, NO_PINS);
    rstn <= 1;
    repeat (4) @(posedge mclk);
    rd(6'h1b, d);
    chk("latch reset", d, LATCH_RESET);
    foreach (rows[i]) begin
      wr(rows[i][27:22], rows[i][21:14]);
      rd(rows[i][13:8], d);
      chk("register row", d, rows[i][7:0]);
    end
    chk("pa_oe", pa_oe, 8'h3c);
    chk("pa_out driven", pa_out & 8'h3c, 8'h24);
    chk("pa_pullup", pa_pullup, 8'h81);
    chk("pb_pullup", pb_pullup, 8'h18);
    ext_en <= 16'hffff; ext_val <= 16'h9669;
    repeat (3) @(posedge mclk);
    rd(6'h19, d);
    chk("port a sense", d, 8'h65);
    rd(6'h16, d);
    chk("port b sense", d, 8'h56);
    chk("alt inputs", cin, 7'h2e);
    bitop(6'h1a, 3'h1, 1);
    bitop(6'h1b, 3'h2, 0);
    rd(6'h1a, d);
    chk("bit set", d, 8'h3e);
    rd(6'h1b, d);
    chk("bit clear", d, 8'ha1);
    alt <= 12'h0e0;
    @(posedge mclk) #1;
    chk("tx pin forced out", {pb_oe[3], pb_out[3]}, 2'h3);
    chk("slave clock pin input", pb_oe[7], 0);
    alt <= 12'h383;
    @(posedge mclk) #1;
    chk("master pins", {pb_out[0], pb_oe[0], pb_oe[6], pb_out[5]},
        4'hd);
    ext_en <= 0; alt <= 0;
    wr(MICRO_CONTROL_ADDR, 8'h80);
    #1 chk("ext enable", ext_mem_enable, 1);
    chk("port a pull-ups", pa_pullup, ALL_PINS);
    xm(1, 16'h1234, 8'h77);
    chk("write strobes", {8'(nwr), 8'(nrd)},
        {8'(STROBE_CYCLES), 8'h0});
    xm(0, 16'h1234, 8'h00);
    chk("read back", xmem_rdata, 8'h77);
    chk("address high", addr_high_out, 8'h12);
    chk("read strobes", {8'(nrd), 8'(nale)},
        {8'(STROBE_CYCLES), 8'h1});
    xm(0, 16'h0100, 8'h00);
    chk("internal no strobes", nrd + nwr, 0);
    wr(MICRO_CONTROL_ADDR, 8'h00);
    #1 chk("pins back to ddr", pa_oe, 8'h3e);
    xm(0, 16'h1234, 8'h00);
    chk("disabled read", xmem_rdata, NO_EXT_READ);
    chk("disabled strobes", nrd + nwr + nale, 0);
    wr(6'h1a, 8'hff);
    rstn <= 0;
    #1 chk("async reset tristate", {pa_oe, pb_oe}, 16'h0);
    conclude();
  end
endmodule

// ### bench/pin_sram_model.sv
// far side of both ports: pin drivers, pull-ups and a latched sram
`timescale 1ns/1ps
module pin_sram_model (
  input  wire logic        mclk,
  input  wire logic [7:0]  pa_out,
  input  wire logic [7:0]  pa_oe,
  input  wire logic [7:0]  pa_pullup,
  input  wire logic [7:0]  pb_out,
  input  wire logic [7:0]  pb_oe,
  input  wire logic [7:0]  pb_pullup,
  input  wire logic [7:0]  addr_high_out,
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  output logic      [7:0]  pa_in,
  output logic      [7:0]  pb_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] addr_lo;
  logic [7:0] flt = 8'h55;
  logic [7:0] pa_far;
  logic [7:0] pb_far;
  // unpulled floating lines wander, never a steady guess
  always @(posedge mclk) flt <= ~flt;
  // address latch closes on the falling edge of ale
  always @(negedge ale) addr_lo <= pa_out;
  always @(posedge mclk) if (!wr_n) mem[{addr_high_out, addr_lo}] <= pa_out;
  always_comb begin
    pa_far = ext_en[7:0] & ext_val[7:0] | ~ext_en[7:0] & (pa_pullup | flt);
    pb_far = ext_en[15:8] & ext_val[15:8] | ~ext_en[15:8] & (pb_pullup | flt);
    if (!rd_n) pa_far = mem[{addr_high_out, addr_lo}];
    pa_in = pa_oe & pa_out | ~pa_oe & pa_far;
    pb_in = pb_oe & pb_out | ~pb_oe & pb_far;
  end
endmodule

// ### verilog/bit_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ### verilog/dual_gpio_port.sv
// two 8-bit gpio ports with external data-memory override on port a
`timescale 1ns/1ps

// Overview of operation
// - external memory enable overrides port a and strobe pin directions
// - enable clear: port a pins follow only their latch and direction bits
// - enable clear: accesses above internal sram are never folded back
// - external access: port a is address/data bus, pull-ups kept on
// - address valid on port a at latch strobe fall; strobe low meanwhile
// - read/write strobes pulse low only for external memory accesses
// - latch strobe stays steady during internal accesses
// - single-bit set/clear touches only the chosen bit
// - port a latch, direction, pin sense at 1b, 1a, 19; sense read-only
// - port b latch, direction, pin sense at 18, 17, 16
// - latch address reads the latch; sense address reads the pins
// - direction one drives the latch bit push-pull; zero is input
// - input pin pull-up follows the latch bit; off when output
// - any reset puts all pins high-impedance at once, clock or not
// - pin levels pass clocked synchronisers before the sense path
// - port b bits 0-3: timer0, timer2/timer1, serial2 rx, serial2 tx
// - port b bits 4-7: spi select, mosi, miso, serial clock
// - external memory enable is bit 7 of the micro control register
module dual_gpio_port
  import gpio_port_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [5:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_we,
  input  wire logic        io_re,
  input  wire logic        io_bit_set,
  input  wire logic        io_bit_clr,
  input  wire logic [2:0]  io_bit_sel,
  output logic      [7:0]  io_rdata,
  input  wire logic        xmem_req,
  input  wire logic        xmem_we,
  input  wire logic [15:0] xmem_addr,
  input  wire logic [7:0]  xmem_wdata,
  output logic             xmem_ack,
  output logic      [7:0]  xmem_rdata,
  input  wire logic [7:0]  pa_in,
  output logic      [7:0]  pa_out,
  output logic      [7:0]  pa_oe,
  output logic      [7:0]  pa_pullup,
  input  wire logic [7:0]  pb_in,
  output logic      [7:0]  pb_out,
  output logic      [7:0]  pb_oe,
  output logic      [7:0]  pb_pullup,
  output logic             ext_mem_enable,
  output logic      [7:0]  addr_high_out,
  output logic             ale,
  output logic             rd_n,
  output logic             wr_n,
  input  wire logic        timer0_compare_en,
  input  wire logic        timer0_compare_out,
  input  wire logic        timer2_compare_en,
  input  wire logic        timer2_compare_out,
  input  wire logic        serial2_rx_en,
  input  wire logic        serial2_tx_en,
  input  wire logic        serial2_transmit,
  input  wire logic        spi_enable,
  input  wire logic        spi_master,
  input  wire logic        spi_mosi_out,
  input  wire logic        spi_miso_out,
  input  wire logic        spi_sck_out,
  output logic             timer0_count_in,
  output logic             timer1_count_in,
  output logic             serial2_receive,
  output logic             spi_ss_in,
  output logic             spi_mosi_in,
  output logic             spi_miso_in,
  output logic             spi_sck_in
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]  pa_latch;
    logic [7:0]  pa_dir;
    logic [7:0]  pb_latch;
    logic [7:0]  pb_dir;
    logic [7:0]  mcu_ctrl;
    logic [7:0]  rdata;
    xmem_state_e xstate;
    logic [3:0]  xcnt;
    logic        xwe;
    logic [7:0]  xwdata;
    logic [7:0]  bus_out;
    logic        bus_drive;
    logic [7:0]  addr_high;
    logic [7:0]  xrdata;
    logic        xack;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
  } port_state_s;

  localparam port_state_s STATE_RESET = '{
    pa_latch:  LATCH_RESET,     pa_dir:    DIRECTION_RESET,
    pb_latch:  LATCH_RESET,     pb_dir:    DIRECTION_RESET,
    mcu_ctrl:  MICRO_CONTROL_RESET,
    rdata:     UNMAPPED_READ,   xstate:    XS_IDLE,
    xcnt:      4'h0,            xwe:       1'h0,
    xwdata:    8'h00,           bus_out:   8'h00,
    bus_drive: 1'h0,            addr_high: 8'h00,
    xrdata:    8'h00,           xack:      1'h0,
    ale:       1'h0,            rd_n:      1'h1,
    wr_n:      1'h1
  };

  port_state_s st_reg;
  port_state_s st_next;
  logic [1:0]  rst_pipe;
  logic        rst_sync_n;
  logic [7:0]  pa_sync;
  logic [7:0]  pb_sync;
  logic [7:0]  bit_mask;
  logic        ext_en;
  logic [7:0]  pb_force_in;
  logic [7:0]  pb_force_out;
  logic [7:0]  pb_use_alt;
  logic [7:0]  pb_alt_val;

  function automatic logic [7:0] bit_op(input logic [7:0] old,
                                        input logic [7:0] mask,
                                        input logic       set);
    bit_op = set ? (old | mask) : (old & ~mask);
  endfunction

  // ==========================================================================
  // reset release; assertion reaches all state without a clock edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // ==========================================================================
  // pin synchronisers
  bit_sync #(.WIDTH(8)) u_sync_a (
    .mclk     (mclk),
    .rst_n    (rst_sync_n),
    .async_in (pa_in),
    .sync_out (pa_sync)
  );

  bit_sync #(.WIDTH(8)) u_sync_b (
    .mclk     (mclk),
    .rst_n    (rst_sync_n),
    .async_in (pb_in),
    .sync_out (pb_sync)
  );

  // ==========================================================================
  // next state
  assign ext_en   = st_reg.mcu_ctrl[EXT_MEM_ENABLE_BIT];
  assign bit_mask = BIT_ONE << io_bit_sel;

  always_comb begin
    st_next      = st_reg;
    st_next.xack = 1'h0;
    // sense addresses fall to default: no state changes
    if (io_we) begin
      case (io_addr)
        PORT_A_OUTPUT_LATCH_ADDR: st_next.pa_latch = io_wdata;
        PORT_A_DIRECTION_ADDR:    st_next.pa_dir   = io_wdata;
        PORT_B_OUTPUT_LATCH_ADDR: st_next.pb_latch = io_wdata;
        PORT_B_DIRECTION_ADDR:    st_next.pb_dir   = io_wdata;
        MICRO_CONTROL_ADDR:       st_next.mcu_ctrl = io_wdata;
        default: ;
      endcase
    end
    if (io_bit_set || io_bit_clr) begin
      case (io_addr)
        PORT_A_OUTPUT_LATCH_ADDR:
          st_next.pa_latch = bit_op(st_reg.pa_latch, bit_mask, io_bit_set);
        PORT_A_DIRECTION_ADDR:
          st_next.pa_dir = bit_op(st_reg.pa_dir, bit_mask, io_bit_set);
        PORT_B_OUTPUT_LATCH_ADDR:
          st_next.pb_latch = bit_op(st_reg.pb_latch, bit_mask, io_bit_set);
        PORT_B_DIRECTION_ADDR:
          st_next.pb_dir = bit_op(st_reg.pb_dir, bit_mask, io_bit_set);
        MICRO_CONTROL_ADDR:
          st_next.mcu_ctrl = bit_op(st_reg.mcu_ctrl, bit_mask, io_bit_set);
        default: ;
      endcase
    end
    if (io_re) begin
      case (io_addr)
        PORT_A_OUTPUT_LATCH_ADDR: st_next.rdata = st_reg.pa_latch;
        PORT_A_DIRECTION_ADDR:    st_next.rdata = st_reg.pa_dir;
        PORT_A_PIN_SENSE_ADDR:    st_next.rdata = pa_sync;
        PORT_B_OUTPUT_LATCH_ADDR: st_next.rdata = st_reg.pb_latch;
        PORT_B_DIRECTION_ADDR:    st_next.rdata = st_reg.pb_dir;
        PORT_B_PIN_SENSE_ADDR:    st_next.rdata = pb_sync;
        MICRO_CONTROL_ADDR:       st_next.rdata = st_reg.mcu_ctrl;
        default:                  st_next.rdata = UNMAPPED_READ;
      endcase
    end

    unique case (st_reg.xstate)
      XS_IDLE: begin
        if (xmem_req) begin
          if (!ext_en || (xmem_addr <= INT_SRAM_TOP)) begin
            // no strobes and no wrap into internal ram
            st_next.xack   = 1'h1;
            st_next.xrdata = NO_EXT_READ;
          end else begin
            st_next.xstate    = XS_ADDR;
            st_next.xcnt      = ALE_CYCLES;
            st_next.ale       = 1'h1;
            st_next.bus_out   = xmem_addr[7:0];
            st_next.bus_drive = 1'h1;
            st_next.addr_high = xmem_addr[15:8];
            st_next.xwe       = xmem_we;
            st_next.xwdata    = xmem_wdata;
          end
        end
      end
      XS_ADDR: begin
        if (st_reg.xcnt == CNT_LAST) begin
          // address stays on the bus across the fall
          st_next.ale    = 1'h0;
          st_next.xstate = XS_HOLD;
          st_next.xcnt   = HOLD_CYCLES;
        end else begin
          st_next.xcnt = st_reg.xcnt - CNT_STEP;
        end
      end
      XS_HOLD: begin
        if (st_reg.xcnt == CNT_LAST) begin
          st_next.xstate = XS_STROBE;
          st_next.xcnt   = STROBE_CYCLES;
          st_next.rd_n   = st_reg.xwe;
          st_next.wr_n   = ~st_reg.xwe;
          if (st_reg.xwe) begin
            st_next.bus_out = st_reg.xwdata;
          end else begin
            st_next.bus_drive = 1'h0;
          end
        end else begin
          st_next.xcnt = st_reg.xcnt - CNT_STEP;
        end
      end
      XS_STROBE: begin
        if (st_reg.xcnt == CNT_LAST) begin
          // strobe long enough to cover the synchroniser delay
          st_next.rd_n      = 1'h1;
          st_next.wr_n      = 1'h1;
          st_next.bus_drive = 1'h0;
          st_next.xstate    = XS_IDLE;
          st_next.xack      = 1'h1;
          if (!st_reg.xwe) begin
            st_next.xrdata = pa_sync;
          end
        end else begin
          st_next.xcnt = st_reg.xcnt - CNT_STEP;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // port b alternate overrides; software still owns the ddr/latch bits
  always_comb begin
    pb_force_in  = NO_PINS;
    pb_force_out = NO_PINS;
    pb_use_alt   = NO_PINS;
    pb_alt_val   = NO_PINS;
    pb_use_alt[0]   = timer0_compare_en;
    pb_alt_val[0]   = timer0_compare_out;
    pb_use_alt[1]   = timer2_compare_en;
    pb_alt_val[1]   = timer2_compare_out;
    pb_force_in[2]  = serial2_rx_en;
    pb_force_out[3] = serial2_tx_en & rst_sync_n;
    pb_use_alt[3]   = serial2_tx_en;
    pb_alt_val[3]   = serial2_transmit;
    pb_force_in[4]  = spi_enable & ~spi_master;
    pb_force_in[5]  = spi_enable & ~spi_master;
    pb_use_alt[5]   = spi_enable & spi_master;
    pb_alt_val[5]   = spi_mosi_out;
    pb_force_in[6]  = spi_enable & spi_master;
    pb_use_alt[6]   = spi_enable & ~spi_master;
    pb_alt_val[6]   = spi_miso_out;
    pb_force_in[7]  = spi_enable & ~spi_master;
    pb_use_alt[7]   = spi_enable & spi_master;
    pb_alt_val[7]   = spi_sck_out;
  end

  // ==========================================================================
  // pad cells
  for (genvar n = 0; n < 8; n++) begin : g_pin
    gpio_pin_cell u_pa (
      .dir_bit      (st_reg.pa_dir[n]),
      .latch_bit    (st_reg.pa_latch[n]),
      .force_in     (ext_en & ~st_reg.bus_drive),
      .force_out    (ext_en & st_reg.bus_drive),
      .use_alt      (ext_en),
      .alt_val      (st_reg.bus_out[n]),
      .force_pullup (ext_en),
      .pin_out      (pa_out[n]),
      .pin_oe       (pa_oe[n]),
      .pin_pullup   (pa_pullup[n])
    );
    gpio_pin_cell u_pb (
      .dir_bit      (st_reg.pb_dir[n]),
      .latch_bit    (st_reg.pb_latch[n]),
      .force_in     (pb_force_in[n]),
      .force_out    (pb_force_out[n]),
      .use_alt      (pb_use_alt[n]),
      .alt_val      (pb_alt_val[n]),
      .force_pullup (1'h0),
      .pin_out      (pb_out[n]),
      .pin_oe       (pb_oe[n]),
      .pin_pullup   (pb_pullup[n])
    );
  end

  // ==========================================================================
  // outputs; strobes masked if the enable drops mid-access
  assign io_rdata        = st_reg.rdata;
  assign xmem_ack        = st_reg.xack;
  assign xmem_rdata      = st_reg.xrdata;
  assign ext_mem_enable  = ext_en;
  assign addr_high_out   = st_reg.addr_high;
  assign ale             = st_reg.ale & ext_en;
  assign rd_n            = st_reg.rd_n | ~ext_en;
  assign wr_n            = st_reg.wr_n | ~ext_en;
  assign timer0_count_in = pb_sync[0];
  assign timer1_count_in = pb_sync[1];
  assign serial2_receive = pb_sync[2];
  assign spi_ss_in       = pb_sync[4];
  assign spi_mosi_in     = pb_sync[5];
  assign spi_miso_in     = pb_sync[6];
  assign spi_sck_in      = pb_sync[7];

  // ==========================================================================
  // assertions
  property p_strobe_ext;
    @(posedge mclk) disable iff (!rst_sync_n)
    (!rd_n || !wr_n) |-> ext_en && (st_reg.xstate == XS_STROBE);
  endproperty
  a_strobe_ext: assert property (p_strobe_ext)
    else $error("strobe low outside external access");

  property p_ale_low_in_strobe;
    @(posedge mclk) disable iff (!rst_sync_n)
    $fell(ale) |-> !ale throughout (##[1:2] (!rd_n || !wr_n));
  endproperty
  a_ale_low_in_strobe: assert property (p_ale_low_in_strobe)
    else $error("latch strobe not low into data phase");

  property p_addr_valid;
    @(posedge mclk) disable iff (!rst_sync_n)
    ale |=> (pa_oe == ALL_PINS) && (pa_out == $past(st_reg.bus_out));
  endproperty
  a_addr_valid: assert property (p_addr_valid)
    else $error("address not held on port a at latch fall");

  property p_plain_dir;
    @(posedge mclk) disable iff (!rst_sync_n)
    !ext_en |-> (pa_oe == st_reg.pa_dir) && (pa_out == st_reg.pa_latch);
  endproperty
  a_plain_dir: assert property (p_plain_dir)
    else $error("port a not following direction and latch");

  property p_no_fold;
    @(posedge mclk) disable iff (!rst_sync_n)
    (xmem_req && !ext_en && st_reg.xstate == XS_IDLE)
      |=> xmem_ack && (xmem_rdata == NO_EXT_READ) && rd_n && wr_n;
  endproperty
  a_no_fold: assert property (p_no_fold)
    else $error("disabled external access not refused");

  property p_pullup_plain;
    @(posedge mclk) disable iff (!rst_sync_n)
    !ext_en |-> pa_pullup == (~st_reg.pa_dir & st_reg.pa_latch);
  endproperty
  a_pullup_plain: assert property (p_pullup_plain)
    else $error("port a pull-up mismatch");

  property p_pullup_bus;
    @(posedge mclk) disable iff (!rst_sync_n)
    ext_en |-> pa_pullup == ALL_PINS;
  endproperty
  a_pullup_bus: assert property (p_pullup_bus)
    else $error("port a pull-ups off in bus mode");

  property p_bit_set;
    @(posedge mclk) disable iff (!rst_sync_n)
    (io_bit_set && !io_bit_clr && !io_we
      && io_addr == PORT_A_DIRECTION_ADDR)
      |=> st_reg.pa_dir == ($past(st_reg.pa_dir) | $past(bit_mask));
  endproperty
  a_bit_set: assert property (p_bit_set)
    else $error("single-bit set disturbed other bits");

  property p_sense_write;
    @(posedge mclk) disable iff (!rst_sync_n)
    (io_we && !io_bit_set && !io_bit_clr
      && io_addr == PORT_B_PIN_SENSE_ADDR)
      |=> $stable(st_reg.pb_latch) && $stable(st_reg.pb_dir);
  endproperty
  a_sense_write: assert property (p_sense_write)
    else $error("sense write changed port b");

  property p_latch_read;
    @(posedge mclk) disable iff (!rst_sync_n)
    (io_re && io_addr == PORT_B_OUTPUT_LATCH_ADDR)
      |=> io_rdata == $past(st_reg.pb_latch);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch read wrong");

  property p_write_drive;
    @(posedge mclk) disable iff (!rst_sync_n)
    !wr_n |-> (pa_oe == ALL_PINS) && (pa_out == st_reg.xwdata);
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("port a not driving write data");

endmodule

// ### verilog/gpio_pin_cell.sv
// pad control of one port pin: direction, drive value, pull-up, override
`timescale 1ns/1ps
module gpio_pin_cell (
  input  wire logic dir_bit,
  input  wire logic latch_bit,
  input  wire logic force_in,
  input  wire logic force_out,
  input  wire logic use_alt,
  input  wire logic alt_val,
  input  wire logic force_pullup,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pin_pullup
);

  // a forced output wins over a forced input if both are ever raised
  assign pin_oe     = force_out | (dir_bit & ~force_in);
  assign pin_out    = use_alt ? alt_val : latch_bit;
  // pull-up when forced, else only on a non-driven pin whose latch holds one
  assign pin_pullup = force_pullup | (~pin_oe & latch_bit);

endmodule

// ### verilog/gpio_port_pkg.sv
// constants, register map and types for the dual gpio port block
package gpio_port_pkg;

  // ==========================================================================
  // core i/o space register map
  localparam logic [5:0] PORT_B_PIN_SENSE_ADDR    = 6'h16;
  localparam logic [5:0] PORT_B_DIRECTION_ADDR    = 6'h17;
  localparam logic [5:0] PORT_B_OUTPUT_LATCH_ADDR = 6'h18;
  localparam logic [5:0] PORT_A_PIN_SENSE_ADDR    = 6'h19;
  localparam logic [5:0] PORT_A_DIRECTION_ADDR    = 6'h1a;
  localparam logic [5:0] PORT_A_OUTPUT_LATCH_ADDR = 6'h1b;
  localparam logic [5:0] MICRO_CONTROL_ADDR       = 6'h35;

  // ==========================================================================
  // fields and reset values
  localparam int         EXT_MEM_ENABLE_BIT = 7;
  localparam logic [7:0] LATCH_RESET        = 8'h00;
  localparam logic [7:0] DIRECTION_RESET    = 8'h00;
  localparam logic [7:0] MICRO_CONTROL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;
  localparam logic [7:0] NO_EXT_READ        = 8'hff;
  localparam logic [7:0] ALL_PINS           = 8'hff;
  localparam logic [7:0] NO_PINS            = 8'h00;
  localparam logic [7:0] BIT_ONE            = 8'h01;

  // last internal data address; anything above belongs to external memory
  localparam logic [15:0] INT_SRAM_TOP = 16'h045f;

  // ==========================================================================
  // external bus timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int ALE_HIGH_NS    = 4;
  localparam int ADDR_HOLD_NS   = 4;
  localparam int STROBE_NS      = 32;
  localparam int ALE_CYC_I  = (ALE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC_I = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int STRB_CYC_I = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ALE_CYCLES    = 4'((ALE_CYC_I < 1) ? 1 : ALE_CYC_I);
  localparam logic [3:0] HOLD_CYCLES   = 4'((HOLD_CYC_I < 1) ? 1 : HOLD_CYC_I);
  localparam logic [3:0] STROBE_CYCLES = 4'((STRB_CYC_I < 1) ? 1 : STRB_CYC_I);
  localparam logic [3:0] CNT_LAST      = 4'h1;
  localparam logic [3:0] CNT_STEP      = 4'h1;

  // ==========================================================================
  // external bus sequencer states, gray along idle-addr-hold-strobe
  typedef enum logic [1:0] {
    XS_IDLE   = 2'h0,
    XS_ADDR   = 2'h1,
    XS_HOLD   = 2'h3,
    XS_STROBE = 2'h2
  } xmem_state_e;

endpackage
